// ---- core/dflic_top.sv ----
/*
 Frame length register, base address change counter and output port 0
 control (sync delay, sync polarity, port select with forced blanking).
 Assumes all inputs come from logic on REF_CLK: the register master, the
 controller run flag, the fetch engine and the display timing generator.
*/
// Summary of operation
// RULE1: Length writable bits 23:3, low bits zero
// RULE2: New length applies after current frame fetched
// RULE3: Software sets length as pixels times bytes
// RULE4: Length multiple of eight or twenty-four
// RULE5: Readable 32-bit count of base changes
// RULE6: Counter held zero while controller stopped
// RULE7: Only adopted queued address counts as change
// RULE8: Sync outputs delayed zero to three clocks
// RULE9: Line sync polarity bit, reset active low
// RULE10: Field sync polarity bit, reset active low
// RULE11: Unselected port blanks and idles all outputs
// RULE12: Select bit acts at once, no boundary
// RULE13: Software changes port setup only when stopped
// RULE14: Counter adds one per adoption, wraps
`timescale 1ns/1ns
`default_nettype none
module dflic_top
    import dflic_pkg::*;
#(
    parameter int unsigned PIX_W = 24
)
(
    // Clock and reset
    input  wire logic                    REF_CLK,
    input  wire logic                    RST,
    // Register port
    input  wire logic [DFLIC_ADDR_W-1:0] REG_ADDR,
    input  wire logic [DFLIC_DATA_W-1:0] REG_WDATA,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    output logic      [DFLIC_DATA_W-1:0] REG_RDATA,
    // Controller and fetch engine
    input  wire logic                    CONTROLLER_RUN_FLAG,
    input  wire logic                    FETCH_DONE,
    input  wire logic                    BASE_QUEUE_VALID,
    output logic      [DFLIC_LEN_W-1:0]  ACTIVE_LENGTH_UPPER,
    // Timing generator, active high
    input  wire logic                    TIM_HSYNC,
    input  wire logic                    TIM_VSYNC,
    input  wire logic                    TIM_BLANK,
    input  wire logic [PIX_W-1:0]        TIM_PIXEL,
    // Output port 0
    output logic                         PORT0_HSYNC,
    output logic                         PORT0_VSYNC,
    output logic                         PORT0_BLANK,
    output logic      [PIX_W-1:0]        PORT0_PIXEL,
    output logic                         PORT0_CLK_EN
);

    if (PIX_W < 1)
    begin : g_chk
        $error("dflic_top: PIX_W must be at least one");
    end

    // Register decode
    logic wr_len;
    logic wr_cnt;
    logic wr_ctrl;
    logic rd_any;

    assign wr_len  = REG_WR && dflic_hit(REG_ADDR, DFLIC_OFF_LEN);
    assign wr_cnt  = REG_WR && dflic_hit(REG_ADDR, DFLIC_OFF_CNT);
    assign wr_ctrl = REG_WR && dflic_hit(REG_ADDR, DFLIC_OFF_CTRL0);
    assign rd_any  = REG_RD;

    // Frame length
    logic                   stopped;
    logic                   len_apply;
    logic [DFLIC_LEN_W-1:0] len_pend;

    assign stopped   = !CONTROLLER_RUN_FLAG;
    // No frame is in flight while stopped, so a new length may load at once
    assign len_apply = FETCH_DONE || stopped; // RULE2

    dflic_len_shadow u_len
    (
        .clk    (REF_CLK),
        .rst    (RST),
        .wr_en  (wr_len),
        .wr_val (REG_WDATA[DFLIC_LEN_MSB:DFLIC_LEN_LSB]),
        .pend_q (len_pend),
        .apply  (len_apply),
        .act_q  (ACTIVE_LENGTH_UPPER)
    );

    // Base address change counter
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        adopt;

    // Reuse of the last address on an empty queue is not a change
    assign adopt = FETCH_DONE && BASE_QUEUE_VALID; // RULE7

    always_comb
    begin
        cnt_d = cnt_q;
        if (stopped)
        begin
            cnt_d = DFLIC_CNT_RST; // RULE6
        end
        else if (adopt)
        begin
            // The hardware count wins over a software write in the same cycle
            cnt_d = cnt_q + DFLIC_CNT_STEP; // RULE14
        end
        else if (wr_cnt)
        begin
            cnt_d = REG_WDATA; // RULE5
        end
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            cnt_q <= DFLIC_CNT_RST;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    // Port 0 control register
    dflic_delay_type dly_q;
    dflic_delay_type dly_d;
    logic            hpol_q;
    logic            hpol_d;
    logic            vpol_q;
    logic            vpol_d;
    logic            sel_q;
    logic            sel_d;

    always_comb
    begin
        dly_d  = dly_q;
        hpol_d = hpol_q;
        vpol_d = vpol_q;
        sel_d  = sel_q;
        if (wr_ctrl)
        begin
            dly_d  = REG_WDATA[DFLIC_DLY_MSB:DFLIC_DLY_LSB]; // RULE8
            hpol_d = REG_WDATA[DFLIC_HPOL_BIT]; // RULE9
            vpol_d = REG_WDATA[DFLIC_VPOL_BIT]; // RULE10
            sel_d  = REG_WDATA[DFLIC_SEL_BIT]; // RULE12
        end
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            dly_q  <= DFLIC_DLY_RST;
            hpol_q <= DFLIC_POL_RST;
            vpol_q <= DFLIC_POL_RST;
            sel_q  <= DFLIC_SEL_RST;
        end
        else
        begin
            dly_q  <= dly_d;
            hpol_q <= hpol_d;
            vpol_q <= vpol_d;
            sel_q  <= sel_d;
        end
    end

    // Read data, valid only in the cycle after the strobe
    logic [31:0] rdata_d;

    always_comb
    begin
        rdata_d = DFLIC_RD_NONE;
        if (!rd_any)
        begin
            rdata_d = DFLIC_RD_NONE;
        end
        else if (dflic_hit(REG_ADDR, DFLIC_OFF_LEN))
        begin
            rdata_d[DFLIC_LEN_MSB:DFLIC_LEN_LSB] = len_pend;
            rdata_d[DFLIC_LEN_LSB-1:0]           = DFLIC_LEN_LO_VAL; // RULE1
        end
        else if (dflic_hit(REG_ADDR, DFLIC_OFF_CNT))
        begin
            rdata_d = cnt_q; // RULE5
        end
        else if (dflic_hit(REG_ADDR, DFLIC_OFF_CTRL0))
        begin
            rdata_d[DFLIC_DLY_MSB:DFLIC_DLY_LSB] = dly_q;
            rdata_d[DFLIC_HPOL_BIT]              = hpol_q;
            rdata_d[DFLIC_VPOL_BIT]              = vpol_q;
            rdata_d[DFLIC_SEL_BIT]               = sel_q;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            REG_RDATA <= DFLIC_RD_NONE;
        end
        else
        begin
            REG_RDATA <= rdata_d;
        end
    end

    // Sync delay; data takes one flop, syncs take one plus the field value
    logic [1:0] sync_dly;

    dflic_sync_delay u_dly
    (
        .clk       (REF_CLK),
        .rst       (RST),
        .sync_in   ({TIM_VSYNC, TIM_HSYNC}),
        .delay_sel (dly_q),
        .sync_out  (sync_dly)
    );

    // Output stage; the select is not tied to frame timing
    logic             hs_d;
    logic             vs_d;
    logic             blank_d;
    logic [PIX_W-1:0] pix_d;
    logic             clk_en_d;

    always_comb
    begin
        if (sel_q)
        begin
            hs_d     = hpol_q ? sync_dly[0] : !sync_dly[0]; // RULE9
            vs_d     = vpol_q ? sync_dly[1] : !sync_dly[1]; // RULE10
            blank_d  = TIM_BLANK;
            pix_d    = TIM_PIXEL;
            clk_en_d = 1'b1;
        end
        else
        begin
            // Syncs idle at their inactive level for the programmed polarity
            hs_d     = !hpol_q; // RULE11
            vs_d     = !vpol_q; // RULE11
            blank_d  = 1'b1;
            pix_d    = '0;
            clk_en_d = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            PORT0_HSYNC  <= 1'b1;
            PORT0_VSYNC  <= 1'b1;
            PORT0_BLANK  <= 1'b1;
            PORT0_PIXEL  <= '0;
            PORT0_CLK_EN <= 1'b0;
        end
        else
        begin
            PORT0_HSYNC  <= hs_d;
            PORT0_VSYNC  <= vs_d;
            PORT0_BLANK  <= blank_d;
            PORT0_PIXEL  <= pix_d;
            PORT0_CLK_EN <= clk_en_d;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    len_low_zero_a: assert property ( // RULE1
        REG_RD && dflic_hit(REG_ADDR, DFLIC_OFF_LEN)
        |=> REG_RDATA[2:0] == 3'h0 && REG_RDATA[31:24] == 8'h00)
        else $error("length low or reserved bits not zero");
    len_wr_read_a: assert property ( // RULE1
        wr_len ##1 (REG_RD && dflic_hit(REG_ADDR, DFLIC_OFF_LEN))
        |=> REG_RDATA[23:3] == $past(REG_WDATA[23:3], 2))
        else $error("length readback wrong");
    cnt_stop_a: assert property (stopped |=> cnt_q == 32'h00000000) // RULE6
        else $error("counter not cleared while stopped");
    cnt_step_a: assert property (!stopped && adopt |=> cnt_q == $past(cnt_q) + 32'h00000001) // RULE14
        else $error("counter did not step by one");
    cnt_reuse_a: assert property ( // RULE7
        !stopped && FETCH_DONE && !BASE_QUEUE_VALID && !wr_cnt |=> $stable(cnt_q))
        else $error("address reuse counted as change");
    cnt_read_a: assert property ( // RULE5
        REG_RD && dflic_hit(REG_ADDR, DFLIC_OFF_CNT) |=> REG_RDATA == $past(cnt_q))
        else $error("counter readback wrong");
    unsel_idle_a: assert property ( // RULE11
        !sel_q |=> PORT0_BLANK && PORT0_PIXEL == '0 && !PORT0_CLK_EN
                   && PORT0_HSYNC == $past(!hpol_q) && PORT0_VSYNC == $past(!vpol_q))
        else $error("unselected port not idle");
    sel_now_a: assert property ($rose(sel_q) |=> PORT0_CLK_EN && PORT0_BLANK == $past(TIM_BLANK)) // RULE12
        else $error("select did not act at once");
    hs_pol_a: assert property ( // RULE9
        sel_q && dly_q == 2'h0 |=> PORT0_HSYNC == ($past(hpol_q) ~^ $past(TIM_HSYNC)))
        else $error("line sync polarity wrong");
    vs_pol_a: assert property ( // RULE10
        sel_q && dly_q == 2'h0 |=> PORT0_VSYNC == ($past(vpol_q) ~^ $past(TIM_VSYNC)))
        else $error("field sync polarity wrong");
    sync_lag_a: assert property ( // RULE8
        (sel_q && hpol_q && dly_q == 2'h2)[*4] |-> PORT0_HSYNC == $past(TIM_HSYNC, 3))
        else $error("sync delay of two clocks wrong");

    cnt_wrap_c: cover property (!stopped && adopt && cnt_q == 32'hFFFFFFFF ##1 cnt_q == 32'h00000000);
    sel_on_c: cover property (wr_ctrl && REG_WDATA[0] ##2 PORT0_CLK_EN);
    len_frame_c: cover property (wr_len && !stopped ##[1:20] FETCH_DONE);

endmodule // dflic_top
`default_nettype wire

// ---- inc/dflic_pkg.sv ----
/*
 Shared constants for the frame length and output port 0 control block:
 register offsets, field positions, reset values and the address decode.
 Assumes a byte-addressed register port of DFLIC_ADDR_W bits.
*/
package dflic_pkg;

    localparam int unsigned DFLIC_ADDR_W     = 8;
    localparam int unsigned DFLIC_DATA_W     = 32;

    // Register byte offsets
    localparam logic [7:0]  DFLIC_OFF_LEN    = 8'h28;
    localparam logic [7:0]  DFLIC_OFF_CNT    = 8'h2C;
    localparam logic [7:0]  DFLIC_OFF_CTRL0  = 8'h40;

    // Frame length fields
    localparam int unsigned DFLIC_LEN_MSB    = 23;
    localparam int unsigned DFLIC_LEN_LSB    = 3;
    localparam int unsigned DFLIC_LEN_W      = DFLIC_LEN_MSB - DFLIC_LEN_LSB + 1;
    localparam logic [2:0]  DFLIC_LEN_LO_VAL = 3'h0;
    localparam logic [20:0] DFLIC_LEN_RST    = 21'h000000;

    // Change counter
    localparam logic [31:0] DFLIC_CNT_RST    = 32'h00000000;
    localparam logic [31:0] DFLIC_CNT_STEP   = 32'h00000001;

    // Port 0 control fields
    localparam int unsigned DFLIC_DLY_MSB    = 7;
    localparam int unsigned DFLIC_DLY_LSB    = 6;
    localparam int unsigned DFLIC_HPOL_BIT   = 4;
    localparam int unsigned DFLIC_VPOL_BIT   = 3;
    localparam int unsigned DFLIC_SEL_BIT    = 0;
    localparam int unsigned DFLIC_DLY_W      = 2;
    localparam int unsigned DFLIC_DLY_MAX    = 3;
    localparam logic [1:0]  DFLIC_DLY_RST    = 2'h0;
    localparam logic        DFLIC_POL_RST    = 1'h0;
    localparam logic        DFLIC_SEL_RST    = 1'h0;

    localparam logic [31:0] DFLIC_RD_NONE    = 32'h00000000;

    typedef logic [DFLIC_DLY_W-1:0] dflic_delay_type;

    function automatic logic dflic_hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

endpackage

// ---- core/dflic_sync_delay.sv ----
/*
 Selectable delay line for the line and field syncs of output port 0.
 Assumes sync inputs and the delay select are on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module dflic_sync_delay
    import dflic_pkg::*;
#(
    parameter int unsigned DEPTH = DFLIC_DLY_MAX,
    parameter int unsigned W     = 2
)
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Syncs in and out
    input  wire logic [W-1:0]        sync_in,
    input  wire dflic_delay_type     delay_sel,
    output logic      [W-1:0]        sync_out
);

    if (DEPTH < DFLIC_DLY_MAX || W < 1)
    begin : g_chk
        $error("dflic_sync_delay: DEPTH too small for the delay field");
    end

    logic [W-1:0] stage_q [DEPTH];
    logic [W-1:0] stage_d [DEPTH];

    always_comb
    begin
        stage_d[0] = sync_in;
        for (int i = 1; i < DEPTH; i++)
        begin
            stage_d[i] = stage_q[i-1];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                stage_q[i] <= '0;
            end
        end
        else
        begin
            stage_q <= stage_d;
        end
    end

    // Field value is the number of clocks added
    assign sync_out = (delay_sel == '0) ? sync_in : stage_q[delay_sel - 2'h1]; // RULE8

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    dly_three_a: assert property ((delay_sel == 2'h3)[*4] |-> sync_out == $past(sync_in, 3)) // RULE8
        else $error("sync delay of three clocks wrong");
    dly_one_a: assert property ((delay_sel == 2'h1)[*2] |-> sync_out == $past(sync_in)) // RULE8
        else $error("sync delay of one clock wrong");
    dly_max_c: cover property ((delay_sel == 2'h3) && sync_in[0] ##3 sync_out[0]);

endmodule // dflic_sync_delay
`default_nettype wire

// ---- core/dflic_len_shadow.sv ----
/*
 Frame length holding pair: the value software last wrote and the value
 the fetch logic uses. Assumes apply is a same-clock pulse or level.
*/
`timescale 1ns/1ns
`default_nettype none
module dflic_len_shadow
    import dflic_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Software side
    input  wire logic                   wr_en,
    input  wire logic [DFLIC_LEN_W-1:0] wr_val,
    output logic      [DFLIC_LEN_W-1:0] pend_q,
    // Fetch side
    input  wire logic                   apply,
    output logic      [DFLIC_LEN_W-1:0] act_q
);

    logic [DFLIC_LEN_W-1:0] pend_d;
    logic [DFLIC_LEN_W-1:0] act_d;

    always_comb
    begin
        pend_d = wr_en ? wr_val : pend_q; // RULE1
        // A write in the apply cycle waits for the next boundary
        act_d  = apply ? pend_q : act_q; // RULE2
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pend_q <= DFLIC_LEN_RST;
            act_q  <= DFLIC_LEN_RST;
        end
        else
        begin
            pend_q <= pend_d;
            act_q  <= act_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    len_hold_a: assert property (!apply |=> $stable(act_q)) // RULE2
        else $error("active length changed mid frame");
    len_take_a: assert property (apply |=> act_q == $past(pend_q)) // RULE2
        else $error("active length not taken at boundary");
    len_apply_c: cover property (wr_en ##[1:8] apply ##1 act_q != $past(act_q));

endmodule // dflic_len_shadow
`default_nettype wire

// ---- tb/dflic_port0_sink.sv ----
/*
 Behavioural downstream transmitter on output port 0: captures a pixel on
 every enabled, unblanked clock. Assumes it shares REF_CLK with the block.
*/
`timescale 1ns/1ns
`default_nettype none
module dflic_port0_sink
    import dflic_pkg::*;
#(
    parameter int unsigned PIX_W = 24
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Port 0 wires
    input  wire logic             blank,
    input  wire logic [PIX_W-1:0] pixel,
    input  wire logic             clk_en,
    // Captured state
    output logic      [PIX_W-1:0] last_pixel_q,
    output logic      [15:0]      beat_count_q
);
    logic [PIX_W-1:0] last_pixel_d;
    logic [15:0]      beat_count_d;

    // A gated clock means no edge reaches the transmitter, so nothing is taken
    always_comb
    begin
        last_pixel_d = last_pixel_q;
        beat_count_d = beat_count_q;
        if (clk_en && !blank)
        begin
            last_pixel_d = pixel;
            beat_count_d = beat_count_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            last_pixel_q <= '0;
            beat_count_q <= 16'h0000;
        end
        else
        begin
            last_pixel_q <= last_pixel_d;
            beat_count_q <= beat_count_d;
        end
    end
endmodule // dflic_port0_sink
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
 Self-checking bench for the frame length, change counter and port 0 block.
 Assumes every design input is driven on REF_CLK rising edges.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import dflic_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        run = 1'b0;
    logic        fetch_done = 1'b0;
    logic        queue_valid = 1'b0;
    logic [20:0] active_len;
    logic        tim_hsync = 1'b0;
    logic        tim_vsync = 1'b0;
    logic        tim_blank = 1'b0;
    logic [23:0] tim_pixel = 24'hA5C3E1;
    logic        port0_hsync;
    logic        port0_vsync;
    logic        port0_blank;
    logic [23:0] port0_pixel;
    logic        port0_clk_en;
    logic [23:0] sink_pixel;
    int          miscompares = 0;
    int          comparisons = 0;
    logic [1:0]  dd;
    logic        hp;
    logic        vp;

    always #4 ref_clk = ~ref_clk;

    dflic_top dflic_top_inst (
        .REF_CLK(ref_clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .CONTROLLER_RUN_FLAG(run), .FETCH_DONE(fetch_done), .BASE_QUEUE_VALID(queue_valid),
        .ACTIVE_LENGTH_UPPER(active_len), .TIM_HSYNC(tim_hsync), .TIM_VSYNC(tim_vsync),
        .TIM_BLANK(tim_blank), .TIM_PIXEL(tim_pixel), .PORT0_HSYNC(port0_hsync),
        .PORT0_VSYNC(port0_vsync), .PORT0_BLANK(port0_blank), .PORT0_PIXEL(port0_pixel),
        .PORT0_CLK_EN(port0_clk_en)
    );

    dflic_port0_sink dflic_port0_sink_inst (
        .clk(ref_clk), .rst(rst), .blank(port0_blank), .pixel(port0_pixel),
        .clk_en(port0_clk_en), .last_pixel_q(sink_pixel), .beat_count_q()
    );

    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk_reg(reg_rdata, exp);
    endtask

    // Write then read back with no idle cycle between the two strobes
    task automatic wr_rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk_reg(reg_rdata, exp);
    endtask

    task automatic fetch(input logic q);
        @(posedge ref_clk);
        fetch_done  <= 1'b1;
        queue_valid <= q;
        @(posedge ref_clk);
        fetch_done  <= 1'b0;
        queue_valid <= 1'b0;
        #1;
    endtask

    initial
    begin
        #100000;
        miscompares++;
        results();
    end

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk_pin(port0_hsync, 1'b1);
        chk_pin(port0_vsync, 1'b1);
        chk_pin(port0_blank, 1'b1);
        chk_pin(port0_clk_en, 1'b0);
        chk_reg({8'h0, port0_pixel}, 32'h0);
        rd_chk(DFLIC_OFF_LEN, 32'h0);
        rd_chk(DFLIC_OFF_CNT, 32'h0);
        rd_chk(DFLIC_OFF_CTRL0, 32'h0);
        rd_chk(8'h30, 32'h0);
        wr_rd_chk(DFLIC_OFF_LEN, 32'h12345677, 32'h00345670);
        wr(DFLIC_OFF_LEN, 32'hFFFFFFFF);
        rd_chk(DFLIC_OFF_LEN, 32'h00FFFFF8);
        chk_reg({11'h0, active_len}, 32'h001FFFFF);
        @(posedge ref_clk);
        run <= 1'b1;
        // 640 by 480 at three bytes per pixel, a multiple of 24 bytes
        wr(DFLIC_OFF_LEN, 32'h000E1000);
        repeat (3) @(posedge ref_clk);
        #1;
        chk_reg({11'h0, active_len}, 32'h001FFFFF);
        fetch(1'b0);
        chk_reg({11'h0, active_len}, 32'h0001C200);
        rd_chk(DFLIC_OFF_CNT, 32'h0);
        repeat (3) fetch(1'b1);
        rd_chk(DFLIC_OFF_CNT, 32'h3);
        wr(DFLIC_OFF_CNT, 32'hFFFFFFFF);
        rd_chk(DFLIC_OFF_CNT, 32'hFFFFFFFF);
        fetch(1'b1);
        rd_chk(DFLIC_OFF_CNT, 32'h0);
        fetch(1'b1);
        @(posedge ref_clk);
        run <= 1'b0;
        rd_chk(DFLIC_OFF_CNT, 32'h0);
        // Port setup is only touched from here on, with the controller stopped
        wr(DFLIC_OFF_CTRL0, 32'hFFFFFFFF);
        rd_chk(DFLIC_OFF_CTRL0, 32'h000000D9);
        wr(DFLIC_OFF_CTRL0, 32'h00000018);
        #1;
        chk_pin(port0_clk_en, 1'b1);
        @(posedge ref_clk);
        #1;
        chk_pin(port0_clk_en, 1'b0);
        chk_pin(port0_hsync, 1'b0);
        chk_pin(port0_vsync, 1'b0);
        chk_pin(port0_blank, 1'b1);
        chk_reg({8'h0, port0_pixel}, 32'h0);
        wr(DFLIC_OFF_CTRL0, 32'h00000001);
        // A fresh pixel value, so the sink cannot pass on a stale capture
        tim_pixel <= 24'h3C5A96;
        repeat (2) @(posedge ref_clk);
        #1;
        chk_pin(port0_clk_en, 1'b1);
        chk_pin(port0_blank, 1'b0);
        chk_reg({8'h0, port0_pixel}, 32'h003C5A96);
        @(posedge ref_clk);
        #1;
        chk_reg({8'h0, sink_pixel}, 32'h003C5A96);
        @(posedge ref_clk);
        tim_blank <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk_pin(port0_blank, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            dd = i[1:0];
            // Line sync active high with the two-clock delay, so the lag check sees it
            hp = dd[1];
            vp = ~dd[1];
            wr(DFLIC_OFF_CTRL0, {24'h0, dd, 1'b0, hp, vp, 2'b00, 1'b1});
            repeat (5) @(posedge ref_clk);
            tim_hsync <= 1'b1;
            tim_vsync <= 1'b1;
            for (int k = 1; k <= 4; k++)
            begin
                @(posedge ref_clk);
                tim_hsync <= 1'b0;
                tim_vsync <= 1'b0;
                #1;
                chk_pin(port0_hsync, (k == i + 1) ? hp : ~hp);
                chk_pin(port0_vsync, (k == i + 1) ? vp : ~vp);
            end
        end
        results();
    end
endmodule // tb_top
`default_nettype wire
